// file: rtl/exc_prio_select.sv
// exception prioritiser and vector selector with an AXI4-Lite register port
module exc_prio_select
  import exc_prio_pkg::*;
#(
  parameter logic [SLOTS-1:0] IMPL = IMPL_SLOTS,
  parameter logic [7:0] PRIO_RESET = RST_PRIO
) (
  input wire logic clk,
  input wire logic rst,
  // axi4-lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // exception sources, active high levels
  input wire logic por_reset_req,
  input wire logic clock_fail_req,
  input wire logic watchdog_req,
  input wire logic illegal_op_req,
  input wire logic sw_trap_req,
  input wire logic nmi_pin_req,
  input wire logic [SLOTS-1:0] irq_req,
  // core sequencer side
  input wire logic core_ccr_we,
  input wire logic core_ccr_i,
  input wire logic core_ccr_x,
  input wire logic svc_begin,
  input wire logic vec_fetch,
  output logic ccr_i_r,
  output logic ccr_x_r,
  output logic exc_pending_r,
  output logic exc_nonmask_r,
  output logic [15:0] exc_vector_r,
  output logic [7:0] exc_code_r,
  output logic vec_valid_r,
  output logic [15:0] vec_hi_addr_r,
  output logic [15:0] vec_lo_addr_r
);

  if (IMPL[SLOTS-1:NMK_FIRST_SLOT] != '0) begin : g_bad_impl
    $error("maskable sources cannot occupy the six nonmaskable slots");
  end

  // software-visible state
  logic [7:0] prio_r;
  logic wd_cme_r;
  logic wd_forced_clock_monitor_enable_r;
  logic [WD_RATE_W-1:0] wd_rate_r;
  logic [SLOTS-1:0] local_en_r;
  logic in_service_r;

  // axi write side holding registers
  logic aw_held_r;
  logic w_held_r;
  logic [ADDR_W-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic [31:0] wmask;
  logic do_write;
  logic wr_hit;
  logic rd_hit;
  logic [31:0] rd_word;

  // prioritiser signals
  logic [SLOTS-1:0] mask_act;
  logic [SLOT_W-1:0] elev_slot;
  logic elev_valid;
  logic clock_fail_act;
  logic watchdog_act;
  logic nmi_act;
  logic win_hit;
  logic win_nmk;
  logic [7:0] win_code;

  // ---------------- axi4-lite write channel ----------------
  assign do_write = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wmask = {{8{wstrb_r[3]}}, {8{wstrb_r[2]}}, {8{wstrb_r[1]}}, {8{wstrb_r[0]}}};

  always_comb begin
    unique case (awaddr_r)
      OFS_CCR, OFS_PRIO, OFS_WDOG, OFS_EN_LO, OFS_EN_HI: wr_hit = 1'b1;
      default: wr_hit = 1'b0;
    endcase
  end

  // each address or data slot reopens only after the response is taken
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held_r <= 1'b0;
      awaddr_r <= '0;
      s_axi_awready <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held_r <= 1'b0;
      end
      s_axi_awready <= !aw_held_r && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      w_held_r <= 1'b0;
      wdata_r <= '0;
      wstrb_r <= '0;
      s_axi_wready <= 1'b0;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb_r <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_r <= 1'b0;
      end
      s_axi_wready <= !w_held_r && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
    end
  end

  // one response per write, held until the master takes it
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ---------------- register updates ----------------
  // condition code mask bits: the core sequencer wins a same-cycle clash
  always_ff @(posedge clk) begin
    if (rst) begin
      ccr_i_r <= RST_CCR_I;
      ccr_x_r <= RST_CCR_X;
    end else if (core_ccr_we) begin
      ccr_i_r <= core_ccr_i;
      ccr_x_r <= core_ccr_x;
    end else if (do_write && awaddr_r == OFS_CCR && wstrb_r[0]) begin
      ccr_i_r <= wdata_r[CCR_I_BIT];
      ccr_x_r <= wdata_r[CCR_X_BIT];
    end
  end

  // elevation code only changes while maskable interrupts are inhibited
  always_ff @(posedge clk) begin
    if (rst) begin
      prio_r <= PRIO_RESET;
    end else if (do_write && awaddr_r == OFS_PRIO && wstrb_r[0] && ccr_i_r) begin
      prio_r <= wdata_r[7:0];
    end
  end

  // watchdog control: monitor enables and the rate that arms the watchdog
  always_ff @(posedge clk) begin
    if (rst) begin
      wd_cme_r <= 1'b0;
      wd_forced_clock_monitor_enable_r <= 1'b0;
      wd_rate_r <= '0;
    end else if (do_write && awaddr_r == OFS_WDOG && wstrb_r[0]) begin
      wd_cme_r <= wdata_r[WD_CME_BIT];
      wd_forced_clock_monitor_enable_r <= wdata_r[WD_FORCED_CLOCK_MONITOR_ENABLE_BIT];
      wd_rate_r <= wdata_r[WD_RATE_LSB +: WD_RATE_W];
    end
  end

  // local enables, one per vector slot; unimplemented slots stay zero
  always_ff @(posedge clk) begin
    if (rst) begin
      local_en_r <= '0;
    end else if (do_write && awaddr_r == OFS_EN_LO) begin
      local_en_r[31:0] <= ((local_en_r[31:0] & ~wmask) | (wdata_r & wmask)) & IMPL[31:0];
    end else if (do_write && awaddr_r == OFS_EN_HI) begin
      local_en_r[63:32] <= ((local_en_r[63:32] & ~wmask) | (wdata_r & wmask)) & IMPL[63:32];
    end
  end

  // ---------------- axi4-lite read channel ----------------
  always_comb begin
    rd_hit = 1'b1;
    rd_word = '0;
    unique case (s_axi_araddr)
      OFS_CCR: begin
        rd_word[CCR_I_BIT] = ccr_i_r;
        rd_word[CCR_X_BIT] = ccr_x_r;
      end
      OFS_PRIO: rd_word[7:0] = prio_r;
      OFS_WDOG: begin
        rd_word[WD_CME_BIT] = wd_cme_r;
        rd_word[WD_FORCED_CLOCK_MONITOR_ENABLE_BIT] = wd_forced_clock_monitor_enable_r;
        rd_word[WD_RATE_LSB +: WD_RATE_W] = wd_rate_r;
      end
      OFS_EN_LO: rd_word = local_en_r[31:0];
      OFS_EN_HI: rd_word = local_en_r[63:32];
      OFS_PEND_LO: rd_word = irq_req[31:0] & IMPL[31:0];
      OFS_PEND_HI: rd_word = irq_req[63:32] & IMPL[63:32];
      OFS_STATUS: begin
        rd_word[7:0] = exc_code_r;
        rd_word[ST_PEND_BIT] = exc_pending_r;
        rd_word[ST_INSVC_BIT] = in_service_r;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // read data is sampled at the address handshake and held until taken
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
    end
  end

  // ---------------- prioritiser ----------------
  // reserved slots are cut out by the implemented map, so they never request
  assign mask_act = irq_req & local_en_r & IMPL & {SLOTS{~ccr_i_r}};
  assign elev_slot = prio_r[SLOT_W:1];
  // only an even code of an implemented slot promotes anything
  assign elev_valid = prio_r[7] && !prio_r[0] && IMPL[elev_slot];
  // the clock monitor needs either enable, the watchdog a nonzero rate
  assign clock_fail_act = clock_fail_req && (wd_cme_r || wd_forced_clock_monitor_enable_r);
  assign watchdog_act = watchdog_req && (wd_rate_r != '0);
  assign nmi_act = nmi_pin_req && !ccr_x_r;

  always_comb begin
    win_hit = 1'b0;
    win_nmk = 1'b0;
    win_code = '0;
    // ascending scan: the last hit is the highest vector address
    for (int s = 0; s < SLOTS; s++) begin
      if (mask_act[s]) begin
        win_hit = 1'b1;
        win_code = {1'b1, SLOT_W'(s), 1'b0};
      end
    end
    // promotion lifts one slot only; the others keep their scan order
    if (elev_valid && mask_act[elev_slot]) begin
      win_code = prio_r;
    end
    // nonmaskables, lowest first so the highest overrides
    if (nmi_act) begin
      win_hit = 1'b1;
      win_nmk = 1'b1;
      win_code = VEC_NMI_PIN[7:0];
    end
    if (sw_trap_req) begin
      win_hit = 1'b1;
      win_nmk = 1'b1;
      win_code = VEC_SW_TRAP[7:0];
    end
    if (illegal_op_req) begin
      win_hit = 1'b1;
      win_nmk = 1'b1;
      win_code = VEC_TRAP[7:0];
    end
    if (watchdog_act) begin
      win_hit = 1'b1;
      win_nmk = 1'b1;
      win_code = VEC_WATCHDOG[7:0];
    end
    if (clock_fail_act) begin
      win_hit = 1'b1;
      win_nmk = 1'b1;
      win_code = VEC_CLOCK_FAIL[7:0];
    end
    if (por_reset_req) begin
      win_hit = 1'b1;
      win_nmk = 1'b1;
      win_code = VEC_RESET[7:0];
    end
  end

  // registered winner for the core, refreshed every clock
  always_ff @(posedge clk) begin
    if (rst) begin
      exc_pending_r <= 1'b0;
      exc_nonmask_r <= 1'b0;
      exc_code_r <= '0;
      exc_vector_r <= VEC_RESET;
    end else begin
      exc_pending_r <= win_hit;
      exc_nonmask_r <= win_nmk;
      exc_code_r <= win_code;
      exc_vector_r <= {VEC_PAGE, win_code};
    end
  end

  // service sequence: begin is marked, the vector is chosen at fetch time
  always_ff @(posedge clk) begin
    if (rst) begin
      in_service_r <= 1'b0;
    end else if (svc_begin) begin
      // a sequence begun on the fetch cycle keeps the flag set
      in_service_r <= 1'b1;
    end else if (vec_fetch) begin
      in_service_r <= 1'b0;
    end
  end

  // vector word addresses for the core, high byte first
  always_ff @(posedge clk) begin
    if (rst) begin
      vec_valid_r <= 1'b0;
      vec_hi_addr_r <= VEC_RESET;
      vec_lo_addr_r <= VEC_RESET | 16'h0001;
    end else begin
      vec_valid_r <= vec_fetch;
      if (vec_fetch) begin
        // a request that vanished mid-sequence falls back to the trap vector
        if (win_hit) begin
          vec_hi_addr_r <= {VEC_PAGE, win_code};
          vec_lo_addr_r <= {VEC_PAGE, win_code | 8'h01};
        end else begin
          vec_hi_addr_r <= VEC_TRAP;
          vec_lo_addr_r <= VEC_TRAP | 16'h0001;
        end
      end
    end
  end

endmodule

// file: rtl/exc_prio_pkg.sv
// constants for the exception prioritiser and vector selector
package exc_prio_pkg;
  // vector space: 64 two-byte slots in the top 128 bytes of the 64 Kbyte map
  localparam int SLOTS = 64;
  localparam int SLOT_W = 6;
  localparam int NMK_FIRST_SLOT = 58;
  localparam logic [7:0] VEC_PAGE = 8'hff;
  // nonmaskable vectors, highest first
  localparam logic [15:0] VEC_RESET = 16'hfffe;
  localparam logic [15:0] VEC_CLOCK_FAIL = 16'hfffc;
  localparam logic [15:0] VEC_WATCHDOG = 16'hfffa;
  localparam logic [15:0] VEC_TRAP = 16'hfff8;
  localparam logic [15:0] VEC_SW_TRAP = 16'hfff6;
  localparam logic [15:0] VEC_NMI_PIN = 16'hfff4;
  // implemented maskable sources, slot = (low byte - 8'h80) / 2
  localparam int SLOT_EXT_IRQ = 57;
  localparam int SLOT_RTI = 56;
  localparam int SLOT_TIMER_C0 = 55;
  localparam int SLOT_TIMER_C7 = 48;
  localparam int SLOT_TIMER_OVF = 47;
  localparam int SLOT_EDGE_OVF = 46;
  localparam int SLOT_EDGE_IN = 45;
  localparam int SLOT_SPI = 44;
  localparam int SLOT_SERIAL0 = 43;
  localparam int SLOT_ADC = 41;
  localparam int SLOT_BUS_LINK = 40;
  localparam int SLOT_DOWN_CNT = 38;
  localparam int SLOT_EDGE2_OVF = 37;
  localparam logic [63:0] TIMER_SLOTS = 64'h00ff0000_00000000;
  localparam logic [63:0] IMPL_SLOTS = TIMER_SLOTS
      | (64'h1 << SLOT_EXT_IRQ) | (64'h1 << SLOT_RTI) | (64'h1 << SLOT_TIMER_OVF)
      | (64'h1 << SLOT_EDGE_OVF) | (64'h1 << SLOT_EDGE_IN) | (64'h1 << SLOT_SPI)
      | (64'h1 << SLOT_SERIAL0) | (64'h1 << SLOT_ADC) | (64'h1 << SLOT_BUS_LINK)
      | (64'h1 << SLOT_DOWN_CNT) | (64'h1 << SLOT_EDGE2_OVF);
  // register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CCR = 8'h00;
  localparam logic [7:0] OFS_PRIO = 8'h04;
  localparam logic [7:0] OFS_WDOG = 8'h08;
  localparam logic [7:0] OFS_EN_LO = 8'h0c;
  localparam logic [7:0] OFS_EN_HI = 8'h10;
  localparam logic [7:0] OFS_PEND_LO = 8'h14;
  localparam logic [7:0] OFS_PEND_HI = 8'h18;
  localparam logic [7:0] OFS_STATUS = 8'h1c;
  // fields
  localparam int CCR_I_BIT = 0;
  localparam int CCR_X_BIT = 1;
  localparam int WD_CME_BIT = 0;
  localparam int WD_FORCED_CLOCK_MONITOR_ENABLE_BIT = 1;
  localparam int WD_RATE_LSB = 2;
  localparam int WD_RATE_W = 3;
  localparam int ST_PEND_BIT = 8;
  localparam int ST_INSVC_BIT = 9;
  // reset values
  localparam logic RST_CCR_I = 1'b1;
  localparam logic RST_CCR_X = 1'b1;
  localparam logic [7:0] RST_PRIO = 8'hf2;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// file: test/exc_prio_assertions.sv
// assertion checker for the exception prioritiser
module exc_prio_assertions
  import exc_prio_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic por_reset_req,
  input wire logic clock_fail_req,
  input wire logic watchdog_req,
  input wire logic illegal_op_req,
  input wire logic sw_trap_req,
  input wire logic nmi_pin_req,
  input wire logic [SLOTS-1:0] irq_req,
  input wire logic core_ccr_we,
  input wire logic core_ccr_i,
  input wire logic core_ccr_x,
  input wire logic vec_fetch,
  input wire logic ccr_i_r,
  input wire logic ccr_x_r,
  input wire logic exc_pending_r,
  input wire logic exc_nonmask_r,
  input wire logic [15:0] exc_vector_r,
  input wire logic [7:0] exc_code_r,
  input wire logic vec_valid_r,
  input wire logic [15:0] vec_hi_addr_r,
  input wire logic [15:0] vec_lo_addr_r
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic nm_hi;
  assign nm_hi = por_reset_req | clock_fail_req | watchdog_req | illegal_op_req;
  AST_POR: assert property (por_reset_req |=> exc_nonmask_r && exc_vector_r == VEC_RESET)
    else $error("reset request did not win");
  AST_SWTRAP: assert property (sw_trap_req && !nm_hi |=> exc_vector_r == VEC_SW_TRAP)
    else $error("software trap vector wrong");
  AST_XMASK: assert property (ccr_x_r && !nm_hi && !sw_trap_req && irq_req == '0
    |=> !exc_pending_r) else $error("masked pin request taken");
  AST_IMASK: assert property (ccr_i_r && !nm_hi && !sw_trap_req &&
    !(nmi_pin_req && !ccr_x_r) |=> !exc_pending_r) else $error("maskable taken while masked");
  AST_CCR: assert property (core_ccr_we |=> ccr_i_r == $past(core_ccr_i) &&
    ccr_x_r == $past(core_ccr_x)) else $error("mask bits not written");
  AST_CODE: assert property (exc_pending_r |-> exc_vector_r == {VEC_PAGE, exc_code_r} &&
    exc_code_r[7] && !exc_code_r[0]) else $error("vector and code disagree");
  AST_NMK: assert property (exc_pending_r |-> exc_nonmask_r == (exc_code_r >= 8'hf4))
    else $error("nonmaskable flag wrong");
  AST_VALID: assert property (vec_valid_r == $past(vec_fetch))
    else $error("vector valid not one cycle after fetch");
  AST_WORD: assert property (vec_valid_r |-> vec_lo_addr_r == vec_hi_addr_r + 16'h1 &&
    vec_hi_addr_r[15:7] == 9'h1ff) else $error("vector word addresses wrong");
  AST_TRAP: assert property (vec_fetch && !exc_pending_r && !nm_hi && !sw_trap_req &&
    !nmi_pin_req && irq_req == '0 |=> vec_hi_addr_r == VEC_TRAP) else $error("no trap vector");
  cover property (vec_valid_r && vec_hi_addr_r == VEC_TRAP);
  cover property (exc_pending_r && !exc_nonmask_r);
  cover property (por_reset_req ##1 exc_pending_r);
endmodule

bind exc_prio_select exc_prio_assertions i_chk (.clk, .rst, .por_reset_req, .clock_fail_req,
  .watchdog_req, .illegal_op_req, .sw_trap_req, .nmi_pin_req, .irq_req, .core_ccr_we,
  .core_ccr_i, .core_ccr_x, .vec_fetch, .ccr_i_r, .ccr_x_r, .exc_pending_r, .exc_nonmask_r,
  .exc_vector_r, .exc_code_r, .vec_valid_r, .vec_hi_addr_r, .vec_lo_addr_r);

// file: test/exc_core_model.sv
// core sequencer model: starts service, fetches vectors, writes mask bits
module exc_core_model (
  input wire logic clk,
  output logic svc_begin,
  output logic vec_fetch,
  output logic core_ccr_we,
  output logic core_ccr_i,
  output logic core_ccr_x
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    {svc_begin, vec_fetch, core_ccr_we} = 3'h0;
    {core_ccr_i, core_ccr_x} = 2'h3;
  end
  task automatic set_ccr(input logic i, input logic x);
    core_ccr_i <= i;
    core_ccr_x <= x;
    core_ccr_we <= 1'b1;
    @(posedge clk);
    core_ccr_we <= 1'b0;
  endtask
  // dly stretches the gap between service start and vector fetch
  task automatic service(input int dly);
    @(posedge clk);
    svc_begin <= 1'b1;
    @(posedge clk);
    svc_begin <= 1'b0;
    repeat (dly) @(posedge clk);
    vec_fetch <= 1'b1;
    @(posedge clk);
    vec_fetch <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
endmodule

// file: test/exc_prio_select_tb.sv
// self-checking bench for the exception prioritiser
module exc_prio_select_tb
  import exc_prio_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, aw_vld, aw_rdy, w_vld, w_rdy, b_vld, b_rdy, ar_vld, ar_rdy, r_vld, r_rdy;
  logic [7:0] aw_addr, ar_addr, pc;
  logic [31:0] w_data, r_data;
  logic [3:0] w_strb;
  logic [1:0] b_resp, r_resp;
  logic [5:0] nm;
  logic [63:0] irq, en, req;
  logic svc_b, fetch, c_we, c_i, c_x, vec_vld;
  logic [15:0] vec_hi, vec_lo;
  logic [15:0] vq[$];
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 29;
  logic [7:0] codes[8] = '{8'hd8, 8'hda, 8'hdc, 8'hca, 8'hcc, 8'hf2, 8'he0, 8'hd4};
  exc_prio_select i_exc_prio_select (.clk, .rst, .s_axi_awaddr(aw_addr),
    .s_axi_awvalid(aw_vld), .s_axi_awready(aw_rdy), .s_axi_wdata(w_data), .s_axi_wstrb(w_strb),
    .s_axi_wvalid(w_vld), .s_axi_wready(w_rdy), .s_axi_bresp(b_resp), .s_axi_bvalid(b_vld),
    .s_axi_bready(b_rdy), .s_axi_araddr(ar_addr), .s_axi_arvalid(ar_vld),
    .s_axi_arready(ar_rdy), .s_axi_rdata(r_data), .s_axi_rresp(r_resp), .s_axi_rvalid(r_vld),
    .s_axi_rready(r_rdy), .por_reset_req(nm[0]), .clock_fail_req(nm[1]),
    .watchdog_req(nm[2]), .illegal_op_req(nm[3]), .sw_trap_req(nm[4]), .nmi_pin_req(nm[5]),
    .irq_req(irq), .core_ccr_we(c_we), .core_ccr_i(c_i), .core_ccr_x(c_x),
    .svc_begin(svc_b), .vec_fetch(fetch), .ccr_i_r(), .ccr_x_r(), .exc_pending_r(),
    .exc_nonmask_r(), .exc_vector_r(), .exc_code_r(), .vec_valid_r(vec_vld),
    .vec_hi_addr_r(vec_hi), .vec_lo_addr_r(vec_lo));
  exc_core_model i_core (.clk, .svc_begin(svc_b), .vec_fetch(fetch), .core_ccr_we(c_we),
    .core_ccr_i(c_i), .core_ccr_x(c_x));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude();
    if (mismatches == 0 && n_tests > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic cmp_vec(input logic [15:0] e);
    n_tests++;
    if ({vec_hi, vec_lo} !== {e, e + 16'h1}) begin
      mismatches++;
      $display("[FAIL] %0t vector %h expected %h", $time, vec_hi, e);
    end
  endtask
  task automatic cmp_rd(input logic [33:0] e);
    n_tests++;
    if ({r_resp, r_data} !== e) begin
      mismatches++;
      $display("[FAIL] %0t read %h expected %h", $time, {r_resp, r_data}, e);
    end
  endtask
  task automatic cmp_resp(input logic [1:0] e);
    n_tests++;
    if (b_resp !== e) begin
      mismatches++;
      $display("[FAIL] %0t write response %h expected %h", $time, b_resp, e);
    end
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (vec_vld) cmp_vec(vq.size() > 0 ? vq.pop_front() : 16'hx);
    if (r_vld && r_rdy) cmp_rd(rq.size() > 0 ? rq.pop_front() : 34'hx);
    if (b_vld && b_rdy) cmp_resp(bq.size() > 0 ? bq.pop_front() : 2'bx);
    if (cyc == 6000) begin
      mismatches++;
      conclude();
    end
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ga, gw;
    {ga, gw} = 2'h0;
    bq.push_back(er);
    aw_addr <= a;
    w_data <= d;
    {aw_vld, w_vld, b_rdy} <= 3'h7;
    while (!(ga && gw)) begin
      @(posedge clk);
      if (aw_rdy) ga = 1'b1;
      if (w_rdy) gw = 1'b1;
      if (ga) aw_vld <= 1'b0;
      if (gw) w_vld <= 1'b0;
    end
    do @(posedge clk); while (!b_vld);
    b_rdy <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [33:0] e);
    rq.push_back(e);
    ar_addr <= a;
    {ar_vld, r_rdy} <= 2'h3;
    do @(posedge clk); while (!ar_rdy);
    ar_vld <= 1'b0;
    do @(posedge clk); while (!r_vld);
    r_rdy <= 1'b0;
    @(posedge clk);
  endtask
  task automatic svc(input logic [15:0] e);
    vq.push_back(e);
    i_core.service($random(seed) & 3);
  endtask
  // expected winner: promoted slot if live, else highest live slot, else trap
  function automatic logic [15:0] win(input logic [63:0] e, input logic [7:0] c);
    win = VEC_TRAP;
    for (int s = 0; s < SLOTS; s++) if (e[s]) win = 16'hff80 + 16'(2 * s);
    if (e[c[6:1]]) win = {VEC_PAGE, c};
  endfunction
  initial begin
    rst = 1'b1;
    {aw_vld, w_vld, b_rdy, ar_vld, r_rdy} = 5'h0;
    {aw_addr, ar_addr, w_data, nm, irq} = '0;
    w_strb = 4'hf;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rd(OFS_CCR, {RESP_OKAY, 32'h3});
    rd(OFS_PRIO, {RESP_OKAY, 24'h0, RST_PRIO});
    rd(8'h20, {RESP_SLVERR, 32'h0});
    wr(OFS_CCR, 32'h0, RESP_OKAY);
    rd(OFS_CCR, {RESP_OKAY, 32'h0});
    wr(OFS_STATUS, 32'h0, RESP_SLVERR);
    wr(OFS_WDOG, 32'h7, RESP_OKAY);
    i_core.set_ccr(1'b1, 1'b0);
    for (int k = 0; k < 6; k++) begin
      nm <= 6'h3f << k;
      svc(VEC_RESET - 16'(2 * k));
    end
    i_core.set_ccr(1'b1, 1'b1);
    svc(VEC_TRAP);
    nm <= 6'h0;
    i_core.set_ccr(1'b0, 1'b0);
    wr(OFS_PRIO, 32'hd8, RESP_OKAY);
    rd(OFS_PRIO, {RESP_OKAY, 24'h0, RST_PRIO});
    for (int it = 0; it < 32; it++) begin
      pc = it < 8 ? codes[it] : 8'($random(seed));
      pc[7] = 1'b1;
      pc[0] = 1'b0;
      en = {$random(seed), $random(seed)};
      req = {$random(seed), $random(seed)};
      i_core.set_ccr(1'b1, 1'b0);
      wr(OFS_PRIO, {24'h0, pc}, RESP_OKAY);
      wr(OFS_EN_LO, en[31:0], RESP_OKAY);
      wr(OFS_EN_HI, en[63:32], RESP_OKAY);
      i_core.set_ccr(1'b0, 1'b0);
      irq <= req;
      svc(win(req & en & IMPL_SLOTS, pc));
    end
    rd(OFS_PRIO, {RESP_OKAY, 24'h0, pc});
    rd(OFS_PEND_LO, {RESP_OKAY, req[31:0] & IMPL_SLOTS[31:0]});
    i_core.set_ccr(1'b1, 1'b0);
    svc(VEC_TRAP);
    irq <= '0;
    svc(VEC_TRAP);
    conclude();
  end
endmodule
